/* File: src/asc_baud_gen.sv */
`timescale 1ns/1ps
`include "asc_cfg.svh"
module asc_baud_gen (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic bclk_tick,
   input wire logic [15:0] divisor,
   output logic os_tick
);
   import asc_pkg::*;
   asc_bgen_t st_reg;
   asc_bgen_t st_next;
   logic [15:0] last;

   // zero is outside the legal range, so it runs as divide by one
   assign last = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;

   // one oversampling tick per divisor baud input edges
   always_comb begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (bclk_tick) begin
         if (st_reg.cnt >= last) begin
            st_next.cnt = 16'h0000;
            st_next.tick = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign os_tick = st_reg.tick;

   property p_wrap;
      @(posedge core_clk) disable iff (reset)
      bclk_tick && st_reg.cnt == last && $stable(divisor) |=> os_tick;
   endproperty
   a_wrap: assert property (p_wrap) else $error("divider missed its wrap tick");

   property p_quiet;
      @(posedge core_clk) disable iff (reset)
      !bclk_tick |=> !os_tick;
   endproperty
   a_quiet: assert property (p_quiet) else $error("tick without baud input edge");

   property p_range;
      @(posedge core_clk) disable iff (reset)
      bclk_tick && $stable(divisor) |=> st_reg.cnt <= $past(last);
   endproperty
   a_range: assert property (p_range) else $error("divider count beyond divisor");
endmodule : asc_baud_gen

/* File: src/asc_cfg.svh */
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH
// register byte offsets
`define ASC_OFS_DATA 5'h00
`define ASC_OFS_DIV 5'h04
`define ASC_OFS_LCR 5'h08
`define ASC_OFS_MCR 5'h0c
`define ASC_OFS_LSR 5'h10
`define ASC_OFS_MSR 5'h14
// reset values
`define ASC_DIV_RST 16'h0001
`define ASC_LCR_RST 9'h003
`define ASC_MCR_RST 2'h0
// line control fields
`define ASC_LCR_LEN 1:0
`define ASC_LCR_STOP2 2
`define ASC_LCR_PAR 4:3
`define ASC_LCR_PFIX 5
`define ASC_LCR_BRK 6
`define ASC_LCR_EXT 7
`define ASC_LCR_LOOP 8
// modem control fields
`define ASC_MCR_RTS 0
`define ASC_MCR_DTR 1
// line status fields
`define ASC_LSR_RBF 0
`define ASC_LSR_OVR 1
`define ASC_LSR_PERR 2
`define ASC_LSR_FERR 3
`define ASC_LSR_BRK 4
`define ASC_LSR_TBE 5
`define ASC_LSR_TE 6
// modem status fields
`define ASC_MSR_LVL 3:0
`define ASC_MSR_DLT 7:4
// timing counts
`define ASC_PRE_LAST 2'h3
`define ASC_OS_LAST 4'hf
`define ASC_OS_MID 4'h7
// start, stop and length offset of a frame, in bits
`define ASC_BRK_BASE 4'h7
`endif

/* File: src/asc_channel.sv */
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "asc_cfg.svh"
module asc_channel #(
   parameter bit CHANNEL = 1'b0
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic external_comm_clock,
   input wire logic serial_rx_pin,
   output logic serial_tx_pin,
   input wire logic clear_to_send_in_n,
   input wire logic set_ready_in_n,
   input wire logic carrier_detect_in_n,
   input wire logic ring_indicate_in_n,
   output logic request_to_send_out_n,
   output logic terminal_ready_out_n,
   output logic tx_dma_req_0,
   output logic tx_dma_req_1
);
   import asc_pkg::*;
   asc_chan_t st_reg;
   asc_chan_t st_next;
   logic os_tick;
   logic req;
   logic acc;
   logic wr_dat;
   logic rx_end;
   logic [3:0] md_pin;

   // mask of the programmed character length
   function automatic logic [7:0] dmask(input logic [1:0] len);
      dmask = 8'hff >> (2'h3 - len);
   endfunction : dmask

   // parity bit expected for a masked character
   function automatic logic par_bit(input logic [7:0] d, input logic [8:0] lcr);
      case (asc_par_t'(lcr[`ASC_LCR_PAR]))
         ASC_PEVEN: par_bit = ^d;
         ASC_PODD: par_bit = ~^d;
         ASC_PFIXED: par_bit = lcr[`ASC_LCR_PFIX];
         default: par_bit = 1'b1;
      endcase
   endfunction : par_bit

   // index of the last data bit
   function automatic logic [2:0] last_bit(input logic [8:0] lcr);
      last_bit = {1'b0, lcr[`ASC_LCR_LEN]} + 3'h4;
   endfunction : last_bit

   // byte-lane merge for the low half word
   function automatic logic [15:0] mrg(input logic [15:0] o, input logic [31:0] w, input logic [3:0] be);
      mrg = {be[1] ? w[15:8] : o[15:8], be[0] ? w[7:0] : o[7:0]};
   endfunction : mrg

   assign req = avs_read | avs_write;
   // acceptance is the cycle the master sees waitrequest low
   assign acc = req && !st_reg.waitreq;
   assign wr_dat = acc && avs_write && avs_address == `ASC_OFS_DATA && avs_byteenable[0];
   assign rx_end = os_tick && st_reg.rx_ph == ASC_STOP && st_reg.rx_os == `ASC_OS_LAST;
   assign md_pin = {ring_indicate_in_n, carrier_detect_in_n, set_ready_in_n, clear_to_send_in_n};

   asc_baud_gen u_baud (
      .core_clk(core_clk),
      .reset(reset),
      .bclk_tick(st_reg.bclk),
      .divisor(st_reg.div),
      .os_tick(os_tick)
   );

   always_comb begin
      st_next = st_reg;
      st_next.rx_done = 1'b0;
      // three-stage pin filters, a change counts once stages two and three agree
      st_next.rx_sy = {st_reg.rx_sy[1:0], serial_rx_pin};
      st_next.cc_sy = {st_reg.cc_sy[1:0], external_comm_clock};
      if (st_reg.rx_sy[1] == st_reg.rx_sy[2]) begin
         st_next.rx_f = st_reg.rx_sy[2];
      end
      if (st_reg.cc_sy[1] == st_reg.cc_sy[2]) begin
         st_next.cc_f = st_reg.cc_sy[2];
      end
      for (int i = 0; i < 4; i++) begin
         st_next.md_sy[i] = {st_reg.md_sy[i][1:0], md_pin[i]};
         if (st_reg.md_sy[i][1] == st_reg.md_sy[i][2]) begin
            st_next.md_f[i] = st_reg.md_sy[i][2];
         end
      end

      // baud input edge: internal quarter clock or external rising edge
      st_next.pre = st_reg.pre + 2'h1;
      st_next.bclk = st_reg.lcr[`ASC_LCR_EXT] ? (st_next.cc_f && !st_reg.cc_f)
                                             : (st_reg.pre == `ASC_PRE_LAST);

      // bus: read data captured in the first cycle, stands at acceptance
      st_next.waitreq = !(req && st_reg.waitreq);
      if (req && st_reg.waitreq && avs_read) begin
         case (avs_address)
            `ASC_OFS_DATA: st_next.rdata = {24'h000000, st_reg.rx_buf};
            `ASC_OFS_DIV: st_next.rdata = {16'h0000, st_reg.div};
            `ASC_OFS_LCR: st_next.rdata = {23'h000000, st_reg.lcr};
            `ASC_OFS_MCR: st_next.rdata = {30'h00000000, st_reg.mcr};
            `ASC_OFS_LSR: st_next.rdata = {25'h0000000, st_reg.te, st_reg.tx_buffer_empty_flag, st_reg.brk,
                                           st_reg.ferr, st_reg.perr, st_reg.ovr, st_reg.rx_buffer_full_flag};
            `ASC_OFS_MSR: st_next.rdata = {24'h000000, st_reg.md_dlt, ~st_reg.md_lvl};
            default: st_next.rdata = 32'h00000000;
         endcase
      end
      // read side effects clear only what the snapshot showed
      if (acc && avs_read) begin
         if (avs_address == `ASC_OFS_DATA && !st_reg.rx_done) begin
            st_next.rx_buffer_full_flag = 1'b0;
         end
         if (avs_address == `ASC_OFS_LSR) begin
            st_next.ovr = st_reg.ovr & ~st_reg.rdata[`ASC_LSR_OVR];
            st_next.perr = st_reg.perr & ~st_reg.rdata[`ASC_LSR_PERR];
            st_next.ferr = st_reg.ferr & ~st_reg.rdata[`ASC_LSR_FERR];
            st_next.brk = st_reg.brk & ~st_reg.rdata[`ASC_LSR_BRK];
         end
         if (avs_address == `ASC_OFS_MSR) begin
            st_next.md_dlt = st_reg.md_dlt & ~st_reg.rdata[`ASC_MSR_DLT];
         end
      end
      if (acc && avs_write) begin
         case (avs_address)
            `ASC_OFS_DIV: st_next.div = mrg(st_reg.div, avs_writedata, avs_byteenable);
            `ASC_OFS_LCR: st_next.lcr = 9'(mrg({7'h00, st_reg.lcr}, avs_writedata, avs_byteenable));
            `ASC_OFS_MCR: st_next.mcr = avs_byteenable[0] ? avs_writedata[1:0] : st_reg.mcr;
            default: st_next.mcr = st_reg.mcr;
         endcase
      end

      // transmitter, advancing only on oversampling ticks
      unique case (st_reg.tx_ph)
         ASC_IDLE: begin
            // a write in the same cycle holds the load off by one tick
            if (os_tick && !st_reg.tx_buffer_empty_flag && !wr_dat) begin
               st_next.tx_sh = st_reg.tx_buf & dmask(st_reg.lcr[`ASC_LCR_LEN]);
               st_next.tx_par = par_bit(st_reg.tx_buf & dmask(st_reg.lcr[`ASC_LCR_LEN]), st_reg.lcr);
               st_next.tx_buffer_empty_flag = 1'b1;
               st_next.tx_line = 1'b0;
               st_next.tx_os = 4'h0;
               st_next.tx_ph = ASC_START;
            end
         end
         ASC_START, ASC_DATA, ASC_PAR, ASC_STOP: begin
            if (os_tick) begin
               st_next.tx_os = st_reg.tx_os + 4'h1;
            end
            if (os_tick && st_reg.tx_os == `ASC_OS_LAST) begin
               unique case (st_reg.tx_ph)
                  ASC_START: begin
                     st_next.tx_line = st_reg.tx_sh[0];
                     st_next.tx_cnt = 3'h0;
                     st_next.tx_ph = ASC_DATA;
                  end
                  ASC_DATA: begin
                     st_next.tx_sh = st_reg.tx_sh >> 1;
                     if (st_reg.tx_cnt != last_bit(st_reg.lcr)) begin
                        st_next.tx_cnt = st_reg.tx_cnt + 3'h1;
                        st_next.tx_line = st_reg.tx_sh[1];
                     end else if (st_reg.lcr[`ASC_LCR_PAR] != ASC_PNONE) begin
                        st_next.tx_line = st_reg.tx_par;
                        st_next.tx_ph = ASC_PAR;
                     end else begin
                        st_next.tx_line = 1'b1;
                        st_next.tx_cnt = 3'h0;
                        st_next.tx_ph = ASC_STOP;
                     end
                  end
                  ASC_PAR: begin
                     st_next.tx_line = 1'b1;
                     st_next.tx_cnt = 3'h0;
                     st_next.tx_ph = ASC_STOP;
                  end
                  default: begin
                     if (st_reg.lcr[`ASC_LCR_STOP2] && st_reg.tx_cnt == 3'h0) begin
                        st_next.tx_cnt = 3'h1;
                     end else begin
                        st_next.tx_ph = ASC_IDLE;
                        st_next.te = st_reg.tx_buffer_empty_flag;
                     end
                  end
               endcase
            end
         end
         default: st_next.tx_ph = ASC_IDLE;
      endcase
      // a buffer write wins over any flag update above
      if (wr_dat) begin
         st_next.tx_buf = avs_writedata[7:0];
         st_next.tx_buffer_empty_flag = 1'b0;
         st_next.te = 1'b0;
      end
      // break overrides the line without disturbing the sequencer
      st_next.txd = st_next.tx_line & ~st_next.lcr[`ASC_LCR_BRK];
      st_next.dma = CHANNEL ? {1'b0, st_next.tx_buffer_empty_flag} : {st_next.tx_buffer_empty_flag, 1'b0};

      // receiver; re-arming needs a high line so a break gives one frame only
      if (st_reg.rx_f) begin
         st_next.rx_arm = 1'b1;
      end
      unique case (st_reg.rx_ph)
         ASC_IDLE: begin
            if (os_tick && st_reg.rx_arm && !st_reg.rx_f) begin
               st_next.rx_arm = 1'b0;
               st_next.rx_os = 4'h0;
               st_next.rx_ph = ASC_START;
            end
         end
         ASC_START: begin
            if (os_tick) begin
               st_next.rx_os = st_reg.rx_os + 4'h1;
               if (st_reg.rx_os == `ASC_OS_MID) begin
                  st_next.rx_os = 4'h0;
                  st_next.rx_cnt = 3'h0;
                  st_next.rx_ph = st_reg.rx_f ? ASC_IDLE : ASC_DATA;
               end
            end
         end
         ASC_DATA, ASC_PAR, ASC_STOP: begin
            if (os_tick) begin
               st_next.rx_os = st_reg.rx_os + 4'h1;
            end
            // sixteen ticks after the start midpoint lands on each bit midpoint
            if (os_tick && st_reg.rx_os == `ASC_OS_LAST) begin
               unique case (st_reg.rx_ph)
                  ASC_DATA: begin
                     st_next.rx_sh = {st_reg.rx_f, st_reg.rx_sh[7:1]};
                     st_next.rx_cnt = st_reg.rx_cnt + 3'h1;
                     if (st_reg.rx_cnt == last_bit(st_reg.lcr)) begin
                        st_next.rx_ph = (st_reg.lcr[`ASC_LCR_PAR] != ASC_PNONE) ? ASC_PAR : ASC_STOP;
                     end
                  end
                  ASC_PAR: begin
                     st_next.rx_par = st_reg.rx_f;
                     st_next.rx_ph = ASC_STOP;
                  end
                  default: begin
                     st_next.rx_buf = st_reg.rx_sh >> (2'h3 - st_reg.lcr[`ASC_LCR_LEN]);
                     st_next.rx_buffer_full_flag = 1'b1;
                     st_next.rx_done = 1'b1;
                     st_next.ovr = st_next.ovr | st_reg.rx_buffer_full_flag;
                     st_next.ferr = st_next.ferr | !st_reg.rx_f;
                     if (st_reg.lcr[`ASC_LCR_PAR] != ASC_PNONE
                         && st_reg.rx_par != par_bit(st_next.rx_buf, st_reg.lcr)) begin
                        st_next.perr = 1'b1;
                     end
                     st_next.rx_ph = ASC_IDLE;
                  end
               endcase
            end
         end
         default: st_next.rx_ph = ASC_IDLE;
      endcase

      // break: low for more than a whole frame of ticks
      if (os_tick) begin
         if (st_reg.rx_f) begin
            st_next.brk_cnt = 8'h00;
         end else if (st_reg.brk_cnt != 8'hff) begin
            st_next.brk_cnt = st_reg.brk_cnt + 8'h01;
         end
         if (!st_reg.rx_f && st_reg.brk_cnt == {4'h0, 2'h0, st_reg.lcr[`ASC_LCR_LEN]} + {4'h0, `ASC_BRK_BASE}
             + {7'h00, st_reg.lcr[`ASC_LCR_PAR] != ASC_PNONE} + {7'h00, st_reg.lcr[`ASC_LCR_STOP2]} << 4) begin
            st_next.brk = 1'b1;
         end
      end

      // modem lines, pin level kept active low: ri, dcd, dsr, cts
      st_next.rts_n = ~st_reg.mcr[`ASC_MCR_RTS];
      st_next.dtr_n = ~st_reg.mcr[`ASC_MCR_DTR];
      st_next.md_lvl = st_reg.lcr[`ASC_LCR_LOOP] ? {1'b1, st_reg.dtr_n, st_reg.dtr_n, st_reg.rts_n}
                                                : st_reg.md_f;
      st_next.md_dlt = st_next.md_dlt | (st_next.md_lvl ^ st_reg.md_lvl);
   end

   // one register for all channel state except the baud divider count and tick, which u_baud holds
   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_reg <= '0;
         st_reg.waitreq <= 1'b1;
         st_reg.div <= `ASC_DIV_RST;
         st_reg.lcr <= `ASC_LCR_RST;
         st_reg.mcr <= `ASC_MCR_RST;
         st_reg.rx_sy <= 3'h7;
         st_reg.cc_sy <= 3'h0;
         st_reg.md_sy <= 12'hfff;
         st_reg.rx_f <= 1'b1;
         st_reg.md_f <= 4'hf;
         st_reg.md_lvl <= 4'hf;
         st_reg.tx_line <= 1'b1;
         st_reg.txd <= 1'b1;
         st_reg.tx_buffer_empty_flag <= 1'b1;
         st_reg.te <= 1'b1;
         st_reg.rts_n <= 1'b1;
         st_reg.dtr_n <= 1'b1;
         st_reg.dma <= CHANNEL ? 2'h1 : 2'h2;
      end else begin
         st_reg <= st_next;
      end
   end

   assign avs_readdata = st_reg.rdata;
   assign avs_waitrequest = st_reg.waitreq;
   assign serial_tx_pin = st_reg.txd;
   assign request_to_send_out_n = st_reg.rts_n;
   assign terminal_ready_out_n = st_reg.dtr_n;
   assign tx_dma_req_0 = st_reg.dma[0];
   assign tx_dma_req_1 = st_reg.dma[1];

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   property p_tx_edge;
      $changed(st_reg.tx_line) |-> $past(os_tick);
   endproperty
   a_tx_edge: assert property (p_tx_edge) else $error("serial line moved off a baud edge");

   property p_wr_clears;
      wr_dat |=> !st_reg.tx_buffer_empty_flag && !st_reg.te;
   endproperty
   a_wr_clears: assert property (p_wr_clears) else $error("buffer write left an empty flag set");

   property p_te_set;
      $rose(st_reg.te) |-> st_reg.tx_buffer_empty_flag && st_reg.tx_ph == ASC_IDLE && $past(st_reg.tx_ph) == ASC_STOP;
   endproperty
   a_te_set: assert property (p_te_set) else $error("idle flag set with work pending");

   property p_rx_full;
      rx_end |=> st_reg.rx_buffer_full_flag && st_reg.rx_buf == ($past(st_reg.rx_sh) >> (2'h3 - $past(st_reg.lcr[1:0])));
   endproperty
   a_rx_full: assert property (p_rx_full) else $error("completed character not buffered");

   property p_overrun;
      rx_end && st_reg.rx_buffer_full_flag |=> st_reg.ovr;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overwrite without overrun flag");

   property p_frame_err;
      rx_end && !st_reg.rx_f |=> st_reg.ferr ##1 st_reg.rx_ph == ASC_IDLE;
   endproperty
   a_frame_err: assert property (p_frame_err) else $error("low stop bit not flagged");

   property p_start_ok;
      st_reg.rx_ph == ASC_START && os_tick && st_reg.rx_os == 4'h7 |=> st_reg.rx_ph == ($past(st_reg.rx_f) ? ASC_IDLE : ASC_DATA);
   endproperty
   a_start_ok: assert property (p_start_ok) else $error("start bit midpoint check wrong");

   property p_loop;
      st_reg.lcr[8] |=> st_reg.md_lvl == {1'b1, $past(st_reg.dtr_n), $past(st_reg.dtr_n), $past(st_reg.rts_n)};
   endproperty
   a_loop: assert property (p_loop) else $error("modem loopback mismatch");

   c_tx_done: cover property ($rose(st_reg.te));
   c_rx_char: cover property (rx_end);
   c_break: cover property ($rose(st_reg.brk));
   c_overrun: cover property ($rose(st_reg.ovr));
endmodule : asc_channel

/* File: src/asc_pkg.sv */
package asc_pkg;
   typedef enum logic [2:0] {
      ASC_IDLE = 3'b000,
      ASC_START = 3'b001,
      ASC_DATA = 3'b011,
      ASC_PAR = 3'b010,
      ASC_STOP = 3'b110
   } asc_phase_t;
   typedef enum logic [1:0] {
      ASC_PNONE = 2'h0,
      ASC_PEVEN = 2'h1,
      ASC_PODD = 2'h2,
      ASC_PFIXED = 2'h3
   } asc_par_t;
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } asc_bgen_t;
   typedef struct packed {
      logic waitreq;
      logic [31:0] rdata;
      logic [15:0] div;
      logic [8:0] lcr;
      logic [1:0] mcr;
      logic [2:0] rx_sy;
      logic [2:0] cc_sy;
      logic [3:0][2:0] md_sy;
      logic rx_f;
      logic cc_f;
      logic [3:0] md_f;
      logic [3:0] md_lvl;
      logic [3:0] md_dlt;
      logic [1:0] pre;
      logic bclk;
      asc_phase_t tx_ph;
      logic [7:0] tx_buf;
      logic [7:0] tx_sh;
      logic [3:0] tx_os;
      logic [2:0] tx_cnt;
      logic tx_par;
      logic tx_line;
      logic tx_buffer_empty_flag;
      logic te;
      logic txd;
      asc_phase_t rx_ph;
      logic rx_arm;
      logic [3:0] rx_os;
      logic [2:0] rx_cnt;
      logic [7:0] rx_sh;
      logic rx_par;
      logic [7:0] rx_buf;
      logic rx_done;
      logic rx_buffer_full_flag;
      logic ovr;
      logic perr;
      logic ferr;
      logic brk;
      logic [7:0] brk_cnt;
      logic rts_n;
      logic dtr_n;
      logic [1:0] dma;
   } asc_chan_t;
endpackage : asc_pkg

/* File: tb/asc_channel_test.sv */
`timescale 1ns/1ps
module asc_channel_test;
   logic core_clk, reset, avs_read, avs_write, echo, avs_waitrequest;
   logic tx, rx, ext_clk, rts_n, dtr_n, dma0, dma1;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0] avs_byteenable, modem_n;
   int num_errors = 0;
   int check_count = 0;
   // divisor, line control, byte sent, byte expected back
   typedef struct packed {logic [15:0] div; logic [8:0] lcr; logic [7:0] d, e;} asc_row_t;
   asc_row_t rows [7] = '{'{16'h1, 9'h000, 8'hb5, 8'h15}, '{16'h1, 9'h009, 8'h6a, 8'h2a},
      '{16'h1, 9'h012, 8'hc3, 8'h43}, '{16'h1, 9'h01f, 8'h81, 8'h81}, '{16'h1, 9'h03b, 8'h5c, 8'h5c},
      '{16'h2, 9'h00b, 8'h01, 8'h01}, '{16'h1, 9'h083, 8'ha7, 8'ha7}};
   asc_channel i_dut (.core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .external_comm_clock(ext_clk),
      .serial_rx_pin(rx), .serial_tx_pin(tx), .clear_to_send_in_n(modem_n[0]),
      .set_ready_in_n(modem_n[1]), .carrier_detect_in_n(modem_n[2]), .ring_indicate_in_n(modem_n[3]),
      .request_to_send_out_n(rts_n), .terminal_ready_out_n(dtr_n), .tx_dma_req_0(dma0), .tx_dma_req_1(dma1));
   asc_far_end i_far (.core_clk(core_clk), .echo(echo), .serial_tx_pin(tx), .serial_rx_pin(rx),
      .external_comm_clock(ext_clk), .modem_n(modem_n));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic finish_test;
      if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   // one bus cycle, held until waitrequest is sampled low
   task automatic rw(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      for (n = 0; n < 20; n++) begin
         @(posedge core_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (n == 20) begin
         num_errors++;
         finish_test();
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // one idle edge so a following call never re-drives a strobe in this step
      @(posedge core_clk);
   endtask : rw
   // read until a masked bit shows, bounded
   task automatic poll(input logic [31:0] m);
      int n;
      for (n = 0; n < 2000; n++) begin
         rw(0, 5'h10, 0);
         if ((q & m) !== 0) break;
      end
      if (n == 2000) begin
         num_errors++;
         finish_test();
      end
   endtask : poll
   initial begin
      reset = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      echo = 1'b1;
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      chk("tx idle", 1, tx);
      chk("dma", 2, {dma1, dma0});
      rw(0, 5'h10, 0);
      chk("lsr", 32'h60, q);
      rw(0, 5'h18, 0);
      chk("unmapped", 0, q);
      avs_byteenable <= 4'h2;
      rw(1, 5'h04, 32'hab07);
      avs_byteenable <= 4'hf;
      rw(0, 5'h04, 0);
      chk("div", 32'hab01, q);
      // wrapped frames over all widths, parities and clock sources
      foreach (rows[i]) begin
         rw(1, 5'h04, rows[i].div);
         rw(1, 5'h08, rows[i].lcr);
         rw(1, 5'h00, rows[i].d);
         poll(1);
         chk("row lsr", 1, q & 32'h1f);
         rw(0, 0, 0);
         chk("row data", rows[i].e, q);
         poll(32'h40);
      end
      // second byte waits in the buffer while the first shifts out
      rw(1, 5'h08, 3);
      rw(1, 0, 8'h3c);
      poll(32'h20);
      rw(1, 0, 8'hc5);
      rw(0, 5'h10, 0);
      chk("busy", 0, q & 32'h60);
      chk("dma busy", 0, dma1);
      poll(32'h02);
      chk("overrun", 3, q & 32'h1f);
      rw(0, 0, 0);
      chk("newest", 32'hc5, q);
      poll(32'h40);
      chk("idle", 32'h60, q);
      // far end drives the line: forced parity miss, bad stop, break
      echo <= 1'b0;
      rw(1, 5'h08, 9'h03b);
      i_far.send({1'b1, 1'b0, 8'h96, 1'b0}, 11);
      poll(1);
      chk("perr", 5, q & 32'h1f);
      rw(0, 0, 0);
      chk("lsb first", 32'h96, q);
      rw(1, 5'h08, 3);
      i_far.send({2'b00, 8'h2d, 1'b0}, 10);
      poll(1);
      chk("ferr", 9, q & 32'h1f);
      rw(0, 0, 0);
      // low for exactly one frame is not yet a break
      i_far.send(12'h000, 10);
      repeat (8) @(posedge core_clk);
      rw(0, 5'h10, 0);
      chk("no break", 9, q & 32'h1f);
      rw(0, 0, 0);
      i_far.send(12'h000, 12);
      poll(32'h10);
      chk("rx break", 32'h10, q & 32'h10);
      rw(0, 0, 0);
      rw(1, 5'h08, 9'h043);
      repeat (2) @(posedge core_clk);
      chk("tx break", 0, tx);
      i_far.modem_n <= 4'he;
      repeat (8) @(posedge core_clk);
      rw(0, 5'h14, 0);
      chk("msr", 32'h11, q);
      rw(0, 5'h14, 0);
      chk("msr read", 1, q);
      rw(1, 5'h08, 9'h103);
      rw(1, 5'h0c, 3);
      i_far.modem_n <= 4'hf;
      repeat (8) @(posedge core_clk);
      rw(0, 5'h14, 0);
      chk("loop", 7, q & 32'hf);
      chk("outs", 0, {rts_n, dtr_n});
      // reset in mid-run with a character pending
      rw(1, 0, 8'h55);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      chk("reset pins", 7, {tx, rts_n, dtr_n});
      rw(0, 5'h10, 0);
      chk("reset lsr", 32'h60, q);
      finish_test();
   end
endmodule : asc_channel_test

/* File: tb/asc_far_end.sv */
`timescale 1ns/1ps
// far-end serial device and modem
module asc_far_end (
   input wire logic core_clk,
   input wire logic echo,
   input wire logic serial_tx_pin,
   output logic serial_rx_pin,
   output logic external_comm_clock,
   output logic [3:0] modem_n
);
   logic drv = 1'b1;
   // echo wraps our line back; else the idle line marks high
   assign serial_rx_pin = echo ? serial_tx_pin : drv;
   // 10 MHz comm clock, kept under the baud input ceiling
   initial begin
      external_comm_clock = 1'b0;
      forever #50 external_comm_clock = ~external_comm_clock;
   end
   initial modem_n = 4'hf;
   // n bits, lsb first, 64 core cycles each (divisor 1, internal)
   task automatic send(input logic [11:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         drv <= f[i];
         repeat (64) @(posedge core_clk);
      end
      drv <= 1'b1;
   endtask : send
endmodule : asc_far_end
